/* scm_pkg.sv */
package scm_pkg;

    // ************************************************************
    // Bus geometry and register indices
    // ************************************************************
    localparam int unsigned AW = 26;
    localparam logic [23:0] IDX_MODE = 24'hffff80;
    localparam logic [23:0] IDX_BAUD = 24'hffff81;
    localparam logic [23:0] IDX_CTRL = 24'hffff82;
    localparam logic [23:0] IDX_TXD  = 24'hffff83;
    localparam logic [23:0] IDX_STAT = 24'hffff84;
    localparam logic [23:0] IDX_RXD  = 24'hffff85;
    localparam logic [23:0] IDX_SCMR = 24'hffff86;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'hff;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic       SCMR_RST = 1'h0;

    // ************************************************************
    // Status bit positions
    // ************************************************************
    localparam int unsigned ST_TX_BUFFER_EMPTY_FLAG = 7;
    localparam int unsigned ST_RDRF = 6;
    localparam int unsigned ST_ORER = 5;
    localparam int unsigned ST_FER  = 4;
    localparam int unsigned ST_TX_END_FLAG = 2;

    // ************************************************************
    // Line timing counts
    // ************************************************************
    localparam logic [3:0] OS_LAST    = 4'hf;
    localparam logic [3:0] OS_MID     = 4'h7;
    localparam logic [3:0] ASYNC_BITS = 4'ha;
    localparam logic [3:0] SYNC_BITS  = 4'h8;
    localparam logic [3:0] DATA_LAST  = 4'h7;

    // ************************************************************
    // Register layouts
    // ************************************************************
    typedef struct packed {
        logic       sync_mode;
        logic [4:0] spare;
        logic       baud_clock_divider_sel_hi;
        logic       baud_clock_divider_sel_lo;
    } scm_mode_s;

    typedef struct packed {
        logic tx_int_enable;
        logic rx_int_enable;
        logic tx_enable;
        logic rx_enable;
        logic spare;
        logic tx_end_int_enable;
        logic clock_source_select_hi;
        logic clock_source_select_lo;
    } scm_ctrl_s;

    typedef enum logic [0:0] {
        TX_IDLE  = 1'b0,
        TX_SHIFT = 1'b1
    } scm_tx_e;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } scm_rx_e;

    // Prescaler terminal count: 2 * 4^n - 1
    function automatic logic [6:0] presc_last(input logic [1:0] sel);
        unique case (sel)
            2'h0: presc_last = 7'h01;
            2'h1: presc_last = 7'h07;
            2'h2: presc_last = 7'h1f;
            2'h3: presc_last = 7'h7f;
        endcase
    endfunction : presc_last

endpackage : scm_pkg

/* scm_pair_buf.sv */
module scm_pair_buf #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL_CNT = DEPTH[PW:0];
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wr_ptr_r;
    logic [PW-1:0]    rd_ptr_r;
    logic [PW:0]      count_r;
    logic             push;
    logic             pop;

    function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
        next_ptr = (p == LAST_PTR) ? '0 : p + 1'b1;
    endfunction : next_ptr

    assign in_ready  = (count_r != FULL_CNT);
    assign out_valid = (count_r != '0);
    assign out_data  = mem_r[rd_ptr_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // ************************************************************
    // Storage
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (push)
            mem_r[wr_ptr_r] <= in_data;
    end

    // ************************************************************
    // Pointers and fill level
    // ************************************************************
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= next_ptr(wr_ptr_r);
            if (pop)
                rd_ptr_r <= next_ptr(rd_ptr_r);
            if (push && !pop)
                count_r <= count_r + 1'b1;
            else if (pop && !push)
                count_r <= count_r - 1'b1;
        end
    end

endmodule : scm_pair_buf

/* scm_channel.sv */
// Contract
// - Mode top bit: async or clock-synchronous
// - Two-bit clock select sets baud prescaler
// - Eight-bit divisor; 32 MHz, 31, select 0 gives 250k sync, 31.25k async
// - Control bit 7 gates transmit-empty request
// - Control bit 6 gates receive and error
// - Control bit 2 gates transmit-end request
// - Sync, upper select 0: drive clock out
// - Sync, upper select 1: clock pin input
// - Clock source field is control bits 1:0
// - Buffer-empty sets on disable or shifter load
// - Clear by 0 after read, or DMA
// - Transmit end on disable or last bit with buffer-empty set
// - Smart-card select bit leaves normal operation
module scm_channel (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic [scm_pkg::AW-1:0] avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    output logic                       txd,
    input  wire logic                  rxd,
    input  wire logic                  sck_i,
    output logic                       sck_o,
    output logic                       sck_oe,
    output logic                       tx_data_empty_irq,
    output logic                       rx_full_irq,
    output logic                       rx_error_irq,
    output logic                       tx_end_irq,
    output logic                       smart_card_mode
);

    scm_pkg::scm_mode_s mode_r;
    scm_pkg::scm_ctrl_s ctrl_r;
    scm_pkg::scm_tx_e   tx_st_r;
    scm_pkg::scm_rx_e   rx_st_r;
    logic [7:0]  baud_div_r;
    logic        smart_r;
    logic        ack_r;
    logic [7:0]  rd_byte_r;
    logic [7:0]  rd_byte;
    logic [23:0] word_idx;
    logic        aligned;
    logic        sel_mode, sel_baud, sel_ctrl, sel_txd, sel_stat, sel_rxd, sel_scmr;
    logic        go;
    logic        wr_ok;
    logic [7:0]  wbyte;
    logic        buf_in_ready, buf_out_valid, buf_pop;
    logic [7:0]  buf_data;
    logic [6:0]  pre_cnt_r;
    logic [7:0]  div_cnt_r;
    logic        tick;
    logic [2:0]  rxd_s_r, sck_s_r;
    logic        rxd_lvl_r, sck_lvl_r, sck_prev_r;
    logic        sck_r;
    logic        ext_clk, sync_on, int_run;
    logic        sck_fall, sck_rise;
    logic [9:0]  tx_sh_r;
    logic [3:0]  tx_cnt_r, tx_os_r;
    logic        txd_r;
    logic        tx_load, tx_step, tx_done;
    logic [7:0]  rx_sh_r;
    logic [3:0]  rx_cnt_r, rx_os_r;
    logic        rx_done_r, rx_ferr_r;
    logic [7:0]  rdr_r;
    logic        tx_buffer_empty_flag_r, rdrf_r, orer_r, fer_r, tx_end_flag_r;
    logic [7:0]  seen_r;
    logic [7:0]  stat;
    logic [7:0]  clr;
    logic        dma_clr;

    // ************************************************************
    // Avalon-MM slave
    // ************************************************************
    assign word_idx = avs_address[scm_pkg::AW-1:2];
    assign aligned  = (avs_address[1:0] == 2'h0);
    assign sel_mode = aligned & (word_idx == scm_pkg::IDX_MODE);
    assign sel_baud = aligned & (word_idx == scm_pkg::IDX_BAUD);
    assign sel_ctrl = aligned & (word_idx == scm_pkg::IDX_CTRL);
    assign sel_txd  = aligned & (word_idx == scm_pkg::IDX_TXD);
    assign sel_stat = aligned & (word_idx == scm_pkg::IDX_STAT);
    assign sel_rxd  = aligned & (word_idx == scm_pkg::IDX_RXD);
    assign sel_scmr = aligned & (word_idx == scm_pkg::IDX_SCMR);

    assign go    = (avs_read | avs_write) & ~ack_r & ~(avs_write & sel_txd & ~buf_in_ready);
    assign wr_ok = ack_r & avs_write & avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];
    assign avs_waitrequest = ~ack_r;
    assign avs_readdata    = {24'h000000, rd_byte_r};

    assign stat = {tx_buffer_empty_flag_r, rdrf_r, orer_r, fer_r, 1'h0, tx_end_flag_r, 2'h0};

    always_comb
    begin
        rd_byte = 8'h00;
        if (sel_mode)
            rd_byte = mode_r;
        else if (sel_baud)
            rd_byte = baud_div_r;
        else if (sel_ctrl)
            rd_byte = ctrl_r;
        else if (sel_stat)
            rd_byte = stat;
        else if (sel_rxd)
            rd_byte = rdr_r;
        else if (sel_scmr)
            rd_byte = {7'h00, smart_r};
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ack_r     <= 1'h0;
            rd_byte_r <= 8'h00;
        end
        else
        begin
            ack_r <= go;
            if (go)
                rd_byte_r <= avs_read ? rd_byte : 8'h00;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mode_r     <= scm_pkg::MODE_RST;
            baud_div_r <= scm_pkg::BAUD_RST;
            ctrl_r     <= scm_pkg::CTRL_RST;
            smart_r    <= scm_pkg::SCMR_RST;
        end
        else if (wr_ok)
        begin
            if (sel_mode)
                mode_r <= wbyte;
            if (sel_baud)
                baud_div_r <= wbyte;
            if (sel_ctrl)
                ctrl_r <= wbyte;
            if (sel_scmr)
                smart_r <= wbyte[0];
        end
    end

    // ************************************************************
    // Transmit holding buffer
    // ************************************************************
    scm_pair_buf #(
        .WIDTH (8),
        .DEPTH (2)
    ) u_tx_buf (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (wr_ok & sel_txd),
        .in_ready  (buf_in_ready),
        .in_data   (wbyte),
        .out_valid (buf_out_valid),
        .out_ready (buf_pop),
        .out_data  (buf_data)
    );

    // ************************************************************
    // Baud generator
    // ************************************************************
    assign tick = (ctrl_r.tx_enable | ctrl_r.rx_enable) & (div_cnt_r == baud_div_r)
                & (pre_cnt_r == scm_pkg::presc_last({mode_r.baud_clock_divider_sel_hi,
                                                     mode_r.baud_clock_divider_sel_lo}));

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pre_cnt_r <= 7'h00;
            div_cnt_r <= 8'h00;
        end
        else if (!(ctrl_r.tx_enable | ctrl_r.rx_enable))
        begin
            pre_cnt_r <= 7'h00;
            div_cnt_r <= 8'h00;
        end
        else if (pre_cnt_r == scm_pkg::presc_last({mode_r.baud_clock_divider_sel_hi,
                                                   mode_r.baud_clock_divider_sel_lo}))
        begin
            pre_cnt_r <= 7'h00;
            div_cnt_r <= tick ? 8'h00 : div_cnt_r + 8'h01;
        end
        else
            pre_cnt_r <= pre_cnt_r + 7'h01;
    end

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rxd_s_r    <= 3'h7;
            sck_s_r    <= 3'h7;
            rxd_lvl_r  <= 1'h1;
            sck_lvl_r  <= 1'h1;
            sck_prev_r <= 1'h1;
        end
        else
        begin
            rxd_s_r    <= {rxd_s_r[1:0], rxd};
            sck_s_r    <= {sck_s_r[1:0], sck_i};
            sck_prev_r <= sck_lvl_r;
            if (rxd_s_r[1] == rxd_s_r[2])
                rxd_lvl_r <= rxd_s_r[2];
            if (sck_s_r[1] == sck_s_r[2])
                sck_lvl_r <= sck_s_r[2];
        end
    end

    // ************************************************************
    // Serial clock
    // ************************************************************
    assign sync_on = mode_r.sync_mode & ~smart_r;
    assign ext_clk = ctrl_r.clock_source_select_hi;
    assign int_run = (tx_st_r == scm_pkg::TX_SHIFT)
                   | (ctrl_r.rx_enable & ~ctrl_r.tx_enable & ~rdrf_r);
    assign sck_oe  = mode_r.sync_mode & ~ext_clk;
    assign sck_o   = sck_r;
    assign sck_fall = sync_on & (ext_clk ? (sck_prev_r & ~sck_lvl_r)
                                         : (tick & sck_r & int_run));
    assign sck_rise = sync_on & (ext_clk ? (~sck_prev_r & sck_lvl_r)
                                         : (tick & ~sck_r));

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            sck_r <= 1'h1;
        else if (!sync_on || ext_clk)
            sck_r <= 1'h1;
        else if (tick && (int_run || !sck_r))
            sck_r <= ~sck_r;
    end

    // ************************************************************
    // Transmitter
    // ************************************************************
    assign tx_load = (tx_st_r == scm_pkg::TX_IDLE) & ctrl_r.tx_enable & ~smart_r
                   & buf_out_valid;
    assign buf_pop = tx_load;
    assign tx_step = sync_on ? sck_fall : (tick & (tx_os_r == scm_pkg::OS_LAST));
    assign tx_done = (tx_st_r == scm_pkg::TX_SHIFT)
                   & (sync_on ? (sck_rise & (tx_cnt_r == scm_pkg::SYNC_BITS))
                              : (tx_step & (tx_cnt_r == scm_pkg::ASYNC_BITS)));
    assign txd = txd_r;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_st_r  <= scm_pkg::TX_IDLE;
            tx_sh_r  <= 10'h3ff;
            tx_cnt_r <= 4'h0;
            tx_os_r  <= 4'h0;
            txd_r    <= 1'h1;
        end
        else
        begin
            unique case (tx_st_r)
                scm_pkg::TX_IDLE:
                begin
                    txd_r <= 1'h1;
                    if (tx_load)
                    begin
                        tx_sh_r  <= sync_on ? {2'h3, buf_data} : {1'h1, buf_data, 1'h0};
                        tx_cnt_r <= 4'h0;
                        tx_os_r  <= 4'h0;
                        tx_st_r  <= scm_pkg::TX_SHIFT;
                    end
                end
                scm_pkg::TX_SHIFT:
                begin
                    if (!ctrl_r.tx_enable || smart_r)
                        tx_st_r <= scm_pkg::TX_IDLE;
                    else if (tx_done)
                        tx_st_r <= scm_pkg::TX_IDLE;
                    else if (tx_step)
                    begin
                        txd_r    <= tx_sh_r[0];
                        tx_sh_r  <= {1'h1, tx_sh_r[9:1]};
                        tx_cnt_r <= tx_cnt_r + 4'h1;
                    end
                    if (tick)
                        tx_os_r <= tx_os_r + 4'h1;
                end
            endcase
        end
    end

    // ************************************************************
    // Receiver
    // ************************************************************
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_st_r   <= scm_pkg::RX_IDLE;
            rx_sh_r   <= 8'h00;
            rx_cnt_r  <= 4'h0;
            rx_os_r   <= 4'h0;
            rx_done_r <= 1'h0;
            rx_ferr_r <= 1'h0;
        end
        else
        begin
            rx_done_r <= 1'h0;
            rx_ferr_r <= 1'h0;
            if (!ctrl_r.rx_enable || smart_r)
            begin
                rx_st_r  <= scm_pkg::RX_IDLE;
                rx_cnt_r <= 4'h0;
            end
            else if (sync_on)
            begin
                if (sck_rise)
                begin
                    rx_sh_r  <= {rxd_lvl_r, rx_sh_r[7:1]};
                    rx_cnt_r <= (rx_cnt_r == scm_pkg::DATA_LAST) ? 4'h0 : rx_cnt_r + 4'h1;
                    rx_done_r <= (rx_cnt_r == scm_pkg::DATA_LAST);
                end
            end
            else
            begin
                if (tick)
                    rx_os_r <= rx_os_r + 4'h1;
                unique case (rx_st_r)
                    scm_pkg::RX_IDLE:
                    begin
                        rx_os_r <= 4'h0;
                        if (!rxd_lvl_r)
                            rx_st_r <= scm_pkg::RX_START;
                    end
                    scm_pkg::RX_START:
                        if (tick && rx_os_r == scm_pkg::OS_MID)
                        begin
                            rx_os_r  <= 4'h0;
                            rx_cnt_r <= 4'h0;
                            rx_st_r  <= rxd_lvl_r ? scm_pkg::RX_IDLE : scm_pkg::RX_DATA;
                        end
                    scm_pkg::RX_DATA:
                        if (tick && rx_os_r == scm_pkg::OS_LAST)
                        begin
                            rx_sh_r  <= {rxd_lvl_r, rx_sh_r[7:1]};
                            rx_cnt_r <= rx_cnt_r + 4'h1;
                            if (rx_cnt_r == scm_pkg::DATA_LAST)
                                rx_st_r <= scm_pkg::RX_STOP;
                        end
                    scm_pkg::RX_STOP:
                        if (tick && rx_os_r == scm_pkg::OS_LAST)
                        begin
                            rx_done_r <= 1'h1;
                            rx_ferr_r <= ~rxd_lvl_r;
                            rx_st_r   <= scm_pkg::RX_IDLE;
                        end
                endcase
            end
        end
    end

    // ************************************************************
    // Status flags
    // ************************************************************
    assign dma_clr = wr_ok & sel_txd & ctrl_r.tx_int_enable & tx_buffer_empty_flag_r;

    always_comb
    begin
        clr = 8'h00;
        if (wr_ok && sel_stat)
            clr = seen_r & ~wbyte;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_buffer_empty_flag_r <= 1'h1;
            tx_end_flag_r <= 1'h1;
            rdrf_r <= 1'h0;
            orer_r <= 1'h0;
            fer_r  <= 1'h0;
            seen_r <= 8'h00;
            rdr_r  <= 8'h00;
        end
        else
        begin
            if (!ctrl_r.tx_enable || tx_load)
                tx_buffer_empty_flag_r <= 1'h1;
            else if (clr[scm_pkg::ST_TX_BUFFER_EMPTY_FLAG] || dma_clr)
                tx_buffer_empty_flag_r <= 1'h0;
            if (!ctrl_r.tx_enable || (tx_done && tx_buffer_empty_flag_r))
                tx_end_flag_r <= 1'h1;
            else if (clr[scm_pkg::ST_TX_BUFFER_EMPTY_FLAG] || dma_clr)
                tx_end_flag_r <= 1'h0;
            if (rx_done_r && !rdrf_r)
            begin
                rdrf_r <= 1'h1;
                rdr_r  <= rx_sh_r;
            end
            else if (clr[scm_pkg::ST_RDRF])
                rdrf_r <= 1'h0;
            if (rx_done_r && rdrf_r)
                orer_r <= 1'h1;
            else if (clr[scm_pkg::ST_ORER])
                orer_r <= 1'h0;
            if (rx_ferr_r)
                fer_r <= 1'h1;
            else if (clr[scm_pkg::ST_FER])
                fer_r <= 1'h0;
            if (ack_r && avs_read && sel_stat)
                seen_r <= stat;
            else
                seen_r <= seen_r & ~clr;
        end
    end

    // ************************************************************
    // Request outputs
    // ************************************************************
    assign tx_data_empty_irq = ctrl_r.tx_int_enable & tx_buffer_empty_flag_r;
    assign rx_full_irq       = ctrl_r.rx_int_enable & rdrf_r;
    assign rx_error_irq      = ctrl_r.rx_int_enable & (orer_r | fer_r);
    assign tx_end_irq        = ctrl_r.tx_end_int_enable & tx_end_flag_r;
    assign smart_card_mode   = smart_r;

endmodule : scm_channel

/* scm_channel_monitor.sv */
module scm_channel_monitor (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [25:0] avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic        avs_waitrequest,
    input wire logic        txd,
    input wire logic        sck_oe,
    input wire logic        tx_data_empty_irq,
    input wire logic        rx_full_irq,
    input wire logic        rx_error_irq,
    input wire logic        tx_end_irq
);
    // ********
    // Mirror
    // ********
    logic       mo_r;
    logic [7:0] ct_r;
    wire        wr = avs_write && !avs_waitrequest && avs_byteenable[0];
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mo_r <= 1'b0;
            ct_r <= 8'h00;
        end
        else if (wr && avs_address == {scm_pkg::IDX_MODE, 2'h0})
            mo_r <= avs_writedata[7];
        else if (wr && avs_address == {scm_pkg::IDX_CTRL, 2'h0})
            ct_r <= avs_writedata[7:0];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_txi_gate: assert property (!ct_r[7] |-> !tx_data_empty_irq)
        else $error("tx empty irq while masked");
    chk_rx_gate: assert property (!ct_r[6] |-> !(rx_full_irq || rx_error_irq))
        else $error("rx irq while masked");
    chk_tei_gate: assert property (!ct_r[2] |-> !tx_end_irq)
        else $error("tx end irq while masked");
    chk_sck_dir: assert property (sck_oe == (mo_r && !ct_r[1]))
        else $error("clock pin direction wrong");
    chk_tx_idle: assert property (!ct_r[5] [*3] |-> txd)
        else $error("txd active while disabled");
    chk_off_flags: assert property ($fell(ct_r[5]) |->
        ##[0:2] (tx_end_irq == ct_r[2] && tx_data_empty_irq == ct_r[7]))
        else $error("flags not set on disable");
    chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    chk_rd_answer: assert property (avs_read |-> ##[0:2] !avs_waitrequest)
        else $error("read not answered");
    cover property (rx_full_irq);
    cover property (sck_oe && !txd);
    cover property ($rose(tx_end_irq));
endmodule : scm_channel_monitor

bind scm_channel scm_channel_monitor u_mon (.*);

/* scm_line_model.sv */
module scm_line_model (
    input wire logic       clk,
    input wire logic       txd,
    input wire logic       sck_o,
    input wire logic       sck_oe,
    input wire logic       ext_go,
    output logic           sck_i,
    output logic           rxd,
    output logic     [7:0] got,
    output int             gap
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Line
    // ********
    int  cnt = 0;
    int  last = 0;
    int  half = 0;
    wire line = sck_oe ? sck_o : sck_i;
    assign rxd = txd;
    initial sck_i = 1'b1;
    always @(posedge clk)
    begin
        cnt <= cnt + 1;
        if (ext_go)
            half <= 16;
        else if (half > 0 && cnt % 64 == 0)
        begin
            sck_i <= ~sck_i;
            half <= half - 1;
        end
    end
    always @(posedge line)
    begin
        got <= {txd, got[7:1]};
        gap <= cnt - last;
        last <= cnt;
    end
endmodule : scm_line_model

/* test_serial_channel_mode_control.sv */
module test_serial_channel_mode_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, ext_go = 0;
    logic [scm_pkg::AW-1:0] avs_address = '0;
    logic [31:0]            avs_writedata = '0, avs_readdata;
    logic [3:0]             avs_byteenable = 4'h1;
    logic                   avs_waitrequest, txd, rxd, sck_i, sck_o, sck_oe, smart_card_mode;
    logic                   tx_data_empty_irq, rx_full_irq, rx_error_irq, tx_end_irq;
    logic [7:0]             got, rv;
    logic [15:0]            lf = 16'h3538;
    int                     gap, num_errors = 0, checks = 0, cyc = 0;
    scm_channel dut (.*);
    scm_line_model u_line (.*);
    always #2.5 clk = ~clk;
    // ********
    // Helpers
    // ********
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : nxt
    function automatic int bitclk(input int n, input int d);
        return 4 * (4 ** n) * (d + 1);
    endfunction : bitclk
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [23:0] idx, input logic [7:0] d);
        avs_address <= {idx, 2'h0};
        avs_writedata <= {24'h0, d};
        avs_read <= !w;
        avs_write <= w;
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        rv = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            num_errors++;
            close_out();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        bus(0, scm_pkg::IDX_STAT, 0);
        chk(rv, 8'h84);
        bus(0, 24'hffff87, 0);
        chk(rv, 8'h00);
        for (int n = 0; n < 4; n++)
        begin
            lf = nxt(lf);
            bus(1, scm_pkg::IDX_CTRL, 8'h84);
            bus(1, scm_pkg::IDX_MODE, {6'h20, n[1:0]});
            bus(1, scm_pkg::IDX_BAUD, {6'h0, lf[1:0]});
            bus(1, scm_pkg::IDX_CTRL, 8'ha4);
            bus(1, scm_pkg::IDX_TXD, lf[15:8]);
            wait (tx_end_irq === 1'b1);
            @(posedge clk);
            chk(got, lf[15:8]);
            chk(gap, bitclk(n, lf[1:0]));
            chk({sck_oe, tx_data_empty_irq}, 2'b11);
        end
        bus(1, scm_pkg::IDX_CTRL, 8'h00);
        bus(1, scm_pkg::IDX_CTRL, 8'ha6);
        bus(1, scm_pkg::IDX_TXD, lf[7:0]);
        ext_go <= 1'b1;
        @(posedge clk);
        ext_go <= 1'b0;
        repeat (1200) @(posedge clk);
        chk({sck_oe, got}, {1'b0, lf[7:0]});
        bus(1, scm_pkg::IDX_CTRL, 8'h00);
        bus(1, scm_pkg::IDX_MODE, 8'h00);
        bus(1, scm_pkg::IDX_BAUD, 8'h00);
        bus(1, scm_pkg::IDX_CTRL, 8'h70);
        bus(1, scm_pkg::IDX_TXD, lf[15:8]);
        wait (rx_full_irq === 1'b1);
        @(posedge clk);
        bus(0, scm_pkg::IDX_RXD, 0);
        chk(rv, lf[15:8]);
        bus(1, scm_pkg::IDX_CTRL, 8'hb4);
        bus(0, scm_pkg::IDX_STAT, 0);
        bus(1, scm_pkg::IDX_STAT, 8'h00);
        chk({tx_data_empty_irq, rx_full_irq}, 2'b00);
        bus(1, scm_pkg::IDX_SCMR, 8'h01);
        chk(smart_card_mode, 1'b1);
        close_out();
    end
endmodule : test_serial_channel_mode_control
